// *** src/watchdog_regs.svh ***
// Purpose: register offsets, fields, reset values and timing for the watchdog
// Assumes: 8-bit register port at the documented offset
// Notes: included by bare name
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH
`define WDG_CTRL_ADDR 8'hE6
`define WDG_CTRL_RESET 8'h00
`define WDG_BIT_ENABLE 7
`define WDG_BIT_OVERFLOW_RESET_ENABLE 6
`define WDG_BIT_IRQEN 5
`define WDG_BIT_CLEAR 4
`define WDG_PS_MSB 3
`define WDG_PS_MAX 4'hC
`define WDG_HALF_COUNT 11'h3FF
`define WDG_FULL_COUNT 11'h7FF
`define WDG_RING_HZ 32000
`define WDG_CLK_MHZ 250
`endif

// *** src/watchdog_pkg.sv ***
// Purpose: shared types for the watchdog
// Assumes: nothing
// Notes: constants live in watchdog_regs.svh
package watchdog_pkg;
  typedef struct packed {
    logic enable;
    logic reset_en;
    logic irq_en;
    logic clear;
    logic [3:0] prescale;
  } watchdog_control_t;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } wdg_state_t;
endpackage : watchdog_pkg

// *** src/watchdog_prescaler.sv ***
// Purpose: turns the selected tick source into a counter advance pulse
// Assumes: src_tick is high in each system clock cycle that counts as a source tick
// Notes: division is 2^code, code zero passes every tick
`timescale 1ns/1ps
`default_nettype none
module watchdog_prescaler
#(
  parameter int DIV_WIDTH = 24
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic restart,
  input wire logic src_tick,
  input wire logic [3:0] code,
  output logic adv_tick
);
  logic [DIV_WIDTH-1:0] div_q;
  logic [DIV_WIDTH-1:0] limit;
  wire hit = (div_q == limit);
  // limit is 2^code - 1
  assign limit = (DIV_WIDTH'(1) << code) - DIV_WIDTH'(1);
  assign adv_tick = src_tick && hit;
  // divider counts source ticks
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      div_q <= '0;
    else if (restart || (src_tick && hit))
      div_q <= '0;
    else if (src_tick)
      div_q <= div_q + DIV_WIDTH'(1);
  end
endmodule : watchdog_prescaler
`default_nettype wire

// *** src/watchdog_timer_11bit.sv ***
// Purpose: 11-bit watchdog with half-count interrupt and overflow reset
// Assumes: ring_tick is a 32 kHz ring oscillator tick synchronous to clock
// Notes: in stop mode the ring source keeps the counter running
// Overview of operation
// - reset clears the control register to zero
// - writing enable one clears and restarts counter
// - bit six allows overflow system reset
// - bit five allows half-count interrupt
// - writing bit four clears counter top bit
// - ring control bit six picks counter clock
// - prescale code sets time-out length
// - counter counts up, interrupt at 0x3FF
// - without reset, overflow wraps counter to zero
// - pending flag clears when interrupt is served
// - ring-clocked interrupt releases stop mode
// - ring-clocked counter runs and resets in stop
// - overflow asserts system reset at once
// - interrupt first, reset later unless cleared
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_regs.svh"
module watchdog_timer_11bit
#(
  parameter int DIV_WIDTH = 24
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic ring_osc_control_sel,
  input wire logic ring_tick,
  input wire logic stop_mode,
  input wire logic irq_ack,
  output logic irq_pending,
  output logic stop_release,
  output logic sys_reset_req
);
  watchdog_pkg::watchdog_control_t ctrl_q;
  watchdog_pkg::watchdog_control_t wr_val;
  watchdog_pkg::wdg_state_t state_q;
  logic [10:0] count_q;
  logic [10:0] count_d;
  logic adv_tick;
  logic irq_q;
  logic wake_q;
  logic rst_q;
  logic [7:0] rdata_q;
  // register decode
  wire ctrl_wr = reg_wr && (reg_addr == `WDG_CTRL_ADDR);
  assign wr_val = watchdog_pkg::watchdog_control_t'(reg_wdata);
  wire enable_wr = ctrl_wr && wr_val.enable;
  wire clear_wr = ctrl_wr && wr_val.clear;
  // source: system clock every cycle or ring tick; ring runs in stop
  wire src_tick = ring_osc_control_sel ? ring_tick
                  : !stop_mode;
  wire running = (state_q == watchdog_pkg::ST_RUN);
  wire adv = running && adv_tick && !enable_wr;
  wire at_half = adv && (count_q == `WDG_HALF_COUNT - 11'h001);
  wire at_ovf = adv && (count_q == `WDG_FULL_COUNT);
  watchdog_prescaler #(.DIV_WIDTH(DIV_WIDTH)) u_prescaler
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .restart(enable_wr),
    .src_tick(src_tick),
    .code(ctrl_q.prescale),
    .adv_tick(adv_tick)
  );
  // next count: restart, top-bit clear, or advance with wrap
  always_comb
  begin
    count_d = count_q;
    if (enable_wr)
      count_d = 11'h000;
    else if (adv)
      count_d = count_q + 11'h001;
    if (clear_wr)
      count_d[10] = 1'b0;
  end
  // control register; clear bit never stored
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_q <=
        watchdog_pkg::watchdog_control_t'(`WDG_CTRL_RESET);
    else if (ctrl_wr)
      ctrl_q <= {wr_val.enable, wr_val.reset_en, wr_val.irq_en, 1'b0,
                 wr_val.prescale};
  end
  // run state follows enable bit
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      state_q <= watchdog_pkg::ST_IDLE;
    else
      case (state_q)
        watchdog_pkg::ST_IDLE:
          if (enable_wr)
            state_q <= watchdog_pkg::ST_RUN;
        watchdog_pkg::ST_RUN:
          if (ctrl_wr && !wr_val.enable)
            state_q <= watchdog_pkg::ST_IDLE;
        default:
          state_q <= watchdog_pkg::ST_IDLE;
      endcase
  end
  // counter
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      count_q <= 11'h000;
    else
      count_q <= count_d;
  end
  // pending flag: set wins over acknowledge
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      irq_q <= 1'b0;
    else if (at_half && ctrl_q.irq_en)
      irq_q <= 1'b1;
    else if (irq_ack)
      irq_q <= 1'b0;
  end
  // stop release pulse and overflow reset pulse
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wake_q <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      wake_q <= at_half && ctrl_q.irq_en && stop_mode
                && ring_osc_control_sel;
      rst_q <= at_ovf && ctrl_q.reset_en;
    end
  end
  // read data
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_q <= 8'h00;
    else
      rdata_q <= (reg_addr == `WDG_CTRL_ADDR) ? 8'(ctrl_q) : 8'h00;
  end
  assign reg_rdata = rdata_q;
  assign irq_pending = irq_q;
  assign stop_release = wake_q;
  assign sys_reset_req = rst_q;

  // assertions; multi-step behaviour is built from named sequences
  sequence wake_step_s;
    at_half && ctrl_q.irq_en && stop_mode && ring_osc_control_sel;
  endsequence
  sequence wake_out_s;
    stop_release ##1 !stop_release;
  endsequence
  sequence ovf_step_s;
    at_ovf && ctrl_q.reset_en;
  endsequence
  sequence rst_out_s;
    sys_reset_req ##1 !sys_reset_req;
  endsequence
  sequence stop_ovf_s;
    at_ovf && ctrl_q.reset_en && stop_mode && ring_osc_control_sel;
  endsequence
  ctrl_reset_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    ctrl_wr && wr_val.enable |=> count_q == 11'h000)
    else $error("enable write did not zero counter");
  ovf_reset_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    at_ovf && ctrl_q.reset_en |=> sys_reset_req)
    else $error("overflow reset missing");
  no_reset_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    !$past(ctrl_q.reset_en) |-> !sys_reset_req)
    else $error("reset without enable");
  half_irq_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    at_half && ctrl_q.irq_en |=> irq_pending && count_q == 11'h3FF)
    else $error("half-count interrupt missing");
  wrap_count_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    at_ovf && !clear_wr |=> count_q == 11'h000)
    else $error("counter did not wrap");
  top_clear_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    clear_wr |=> !count_q[10])
    else $error("top bit not cleared");
  clear_bit_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    !ctrl_q.clear)
    else $error("clear bit stored");
  ack_clear_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    irq_ack && !(at_half && ctrl_q.irq_en) |=> !irq_pending)
    else $error("pending not cleared by service");
  idle_hold_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    !running && !ctrl_wr |=> $stable(count_q))
    else $error("counter moved while disabled");
  wake_pulse_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    wake_step_s |=> wake_out_s)
    else $error("stop release pulse missing");
  rst_pulse_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    ovf_step_s |=> rst_out_s)
    else $error("overflow reset not a single pulse");
  stop_reset_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    stop_ovf_s |=> sys_reset_req)
    else $error("no reset in stop mode");
  pend_hold_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    irq_pending && !irq_ack |=> irq_pending)
    else $error("pending dropped without service");
  no_wake_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    !ring_osc_control_sel |=> !stop_release)
    else $error("stop release without ring source");
  count_step_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    running && adv_tick && !ctrl_wr |=> count_q == $past(count_q) + 11'h001)
    else $error("counter did not advance by one");
  clear_read_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    !reg_rdata[`WDG_BIT_CLEAR])
    else $error("clear bit read back as one");
endmodule : watchdog_timer_11bit
`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: self-checking bench for the 11-bit watchdog
// Assumes: ring ticks come every 4 clocks, far faster than a real oscillator
// Notes: timing windows allow a few cycles of pipeline slack
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_regs.svh"
module tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic ring_osc_control_sel = 1'b0;
  logic ring_tick = 1'b0;
  logic stop_mode = 1'b0;
  logic irq_ack = 1'b0;
  logic irq_pending, stop_release, sys_reset_req;
  logic [1:0] tick_cnt = 2'h0;
  logic rst_seen = 1'b0;
  int fail_count = 0;
  int compares = 0;
  watchdog_timer_11bit #(.DIV_WIDTH(24)) u_watchdog_timer_11bit (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ring_osc_control_sel(ring_osc_control_sel), .ring_tick(ring_tick),
    .stop_mode(stop_mode), .irq_ack(irq_ack), .irq_pending(irq_pending),
    .stop_release(stop_release), .sys_reset_req(sys_reset_req));
  // 250 MHz clock
  always #2 clock = ~clock;
  // ring tick every fourth clock; remember any overflow reset pulse
  always @(posedge clock)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    ring_tick <= (tick_cnt == 2'h3);
    if (sys_rst) rst_seen <= 1'b0;
    else if (sys_reset_req === 1'b1) rst_seen <= 1'b1;
  end
  task automatic err(input string msg);
    fail_count++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : err
  task automatic conclude;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic dut_reset;
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
  endtask : dut_reset
  // every drive starts on a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    @(posedge clock);
    @(posedge clock);
    #1;
    compares++;
    if (reg_rdata !== exp) err("register read mismatch");
  endtask : rd_chk
  function automatic logic pick(input int sel);
    return sel == 0 ? irq_pending : sel == 1 ? sys_reset_req : stop_release;
  endfunction : pick
  // waits for an output and checks it arrives within [lo, hi) cycles
  task automatic wait_sig(input int sel, input int lo, input int hi);
    int n;
    n = 0;
    #1;
    while (pick(sel) !== 1'b1 && n < hi)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    compares++;
    if (n < lo || n >= hi) err("output event outside its window");
  endtask : wait_sig
  task automatic t_regs;
    rd_chk(8'hE6, 8'h00);
    rd_chk(8'h10, 8'h00);
    wr(8'h10, 8'hFF);
    rd_chk(8'hE6, 8'h00);
  endtask : t_regs
  task automatic t_irq_wrap;
    wr(8'hE6, 8'hB0);
    wait_sig(0, 1015, 1035);
    @(posedge clock);
    irq_ack <= 1'b1;
    @(posedge clock);
    irq_ack <= 1'b0;
    @(posedge clock);
    #1;
    compares++;
    if (irq_pending !== 1'b0)
      err("pending flag not cleared by ack");
    wait_sig(0, 2030, 2060);
    compares++;
    if (rst_seen !== 1'b0) err("reset pulse while disabled");
    rd_chk(8'hE6, 8'hA0);
  endtask : t_irq_wrap
  task automatic t_overflow;
    dut_reset();
    wr(8'hE6, 8'hC0);
    wait_sig(1, 2040, 2060);
    compares++;
    if (irq_pending !== 1'b0) err("interrupt while disabled");
  endtask : t_overflow
  task automatic t_kick;
    dut_reset();
    wr(8'hE6, 8'hE0);
    wait_sig(0, 1015, 1035);
    repeat (400) @(posedge clock);
    wr(8'hE6, 8'hF0);
    wait_sig(1, 2040, 2060);
  endtask : t_kick
  task automatic t_ring_stop;
    dut_reset();
    ring_osc_control_sel <= 1'b1;
    stop_mode <= 1'b1;
    wr(8'hE6, 8'hE1);
    wait_sig(2, 8160, 8230);
    wait_sig(1, 8180, 8220);
    @(posedge clock);
    stop_mode <= 1'b0;
  endtask : t_ring_stop
  initial
  begin
    dut_reset();
    t_regs();
    t_irq_wrap();
    t_overflow();
    t_kick();
    t_ring_stop();
    conclude();
  end
  // watchdog: all scenarios take about 25000 cycles
  initial
  begin
    #150000;
    fail_count++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
